// File: rtl/spcsr_pkg.sv
package spcsr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned CHAR_W = 9;
  localparam int unsigned FIFO_DEPTH = 2;
  // byte addresses of the bank
  localparam logic [7:0] OFF_TX_CTL = 8'h00;
  localparam logic [7:0] OFF_RX_CTL = 8'h04;
  localparam logic [7:0] OFF_RATE_CTL = 8'h08;
  localparam logic [7:0] OFF_RX_DATA = 8'h0c;
  localparam logic [7:0] OFF_DIV_LOW = 8'h10;
  localparam logic [7:0] OFF_DIV_HIGH = 8'h14;
  // tx_status_control fields
  localparam int unsigned TX_CLK_SRC = 7;
  localparam int unsigned TX_NINE = 6;
  localparam int unsigned TX_ON = 5;
  localparam int unsigned TX_SYNC = 4;
  localparam int unsigned TX_BREAK = 3;
  localparam int unsigned TX_HIGH_SPEED = 2;
  localparam int unsigned TX_SHIFT_EMPTY = 1;
  localparam int unsigned TX_NINTH_DATA = 0;
  // rx_status_control fields
  localparam int unsigned RX_PORT_EN = 7;
  localparam int unsigned RX_NINE = 6;
  localparam int unsigned RX_SINGLE = 5;
  localparam int unsigned RX_CONT = 4;
  localparam int unsigned RX_ADDR_DET = 3;
  localparam int unsigned RX_FRAME_ERR = 2;
  localparam int unsigned RX_OVERRUN = 1;
  localparam int unsigned RX_NINTH_DATA = 0;
  // rate_control fields
  localparam int unsigned RC_AB_OVF = 7;
  localparam int unsigned RC_IDLE = 6;
  localparam int unsigned RC_POLARITY = 4;
  localparam int unsigned RC_WIDE = 3;
  localparam int unsigned RC_WAKE = 1;
  localparam int unsigned RC_AUTOBAUD = 0;
  localparam logic [7:0] RC_IMPL_MASK = 8'hdb;
  // reset values
  localparam logic [7:0] TX_CTL_RST = 8'h02;
  localparam logic [7:0] RX_CTL_RST = 8'h00;
  localparam logic [7:0] RATE_CTL_RST = 8'h40;
  localparam logic [7:0] DIV_RST = 8'h00;
endpackage

// File: rtl/spcsr_rx_fifo.sv
`timescale 1ns/10ps
module spcsr_rx_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = spcsr_pkg::FIFO_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_flush,
  input wire logic i_push,
  input wire logic [WIDTH-1:0] i_data,
  input wire logic i_pop,
  output logic [WIDTH-1:0] o_head,
  output logic [$clog2(DEPTH+1)-1:0] o_level
);
  import spcsr_pkg::*;
  localparam int unsigned LW = $clog2(DEPTH+1);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] rd_ptr;
  logic [PW-1:0] wr_ptr;
  logic do_push;
  logic do_pop;

  // a push when full is dropped here; the level bound is checked below
  assign do_push = i_push && (o_level != LW'(DEPTH));
  assign do_pop = i_pop && (o_level != '0);
  assign o_head = mem[rd_ptr];

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || i_flush) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      o_level <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      o_level <= o_level + LW'(do_push) - LW'(do_pop);
    end
  end

  // payload needs no reset; only pointers and level are control state
  always_ff @(posedge i_clk_sys) begin
    if (do_push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  AST_FIFO_BOUND: assert property (@(posedge i_clk_sys) disable iff
    (!i_rst_n) o_level <= LW'(DEPTH))
    else $error("receive buffer holds more than its depth");
endmodule // spcsr_rx_fifo

// File: rtl/spcsr_rate_gen.sv
`timescale 1ns/10ps
module spcsr_rate_gen #(
  parameter int unsigned WIDTH = spcsr_pkg::DIV_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_restart,
  input wire logic i_wide,
  input wire logic [WIDTH-1:0] i_divisor,
  output logic o_tick
);
  import spcsr_pkg::*;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] limit;

  assign limit = i_wide ? i_divisor : {{(WIDTH-8){1'b0}}, i_divisor[7:0]};

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || i_restart) begin
      count <= '0;
      o_tick <= 1'b0;
    end else if (count >= limit) begin
      count <= '0;
      o_tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      o_tick <= 1'b0;
    end
  end

  AST_DIV_RESTART: assert property (@(posedge i_clk_sys) disable iff
    (!i_rst_n) i_restart |=> count == '0 && !o_tick)
    else $error("rate timer not cleared by divisor write");
endmodule // spcsr_rate_gen

// File: rtl/spcsr_regs.sv
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module spcsr_regs (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [spcsr_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [spcsr_pkg::DATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic o_pready,
  output logic o_pslverr,
  output logic [spcsr_pkg::DATA_W-1:0] o_prdata,
  // status from the character engines
  input wire logic i_tsr_empty,
  input wire logic i_break_done,
  input wire logic i_single_done,
  input wire logic i_rx_busy,
  input wire logic i_rx_valid,
  input wire logic [spcsr_pkg::CHAR_W-1:0] i_rx_char,
  input wire logic i_rx_frame_err,
  input wire logic i_rx_fall,
  input wire logic i_autobaud_done,
  input wire logic i_autobaud_ovf,
  // controls to the character engines
  output logic o_port_enable,
  output logic o_sync_mode,
  output logic o_clock_master,
  output logic o_tx_enable,
  output logic o_tx_nine,
  output logic o_tx_ninth_data,
  output logic o_send_break,
  output logic o_high_speed,
  output logic o_rx_enable,
  output logic o_rx_nine,
  output logic o_polarity,
  output logic o_autobaud_run,
  output logic o_wake_wait,
  output logic o_rate_tick,
  output logic o_receive_pending
);
  import spcsr_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  logic [7:0] tx_ctl;
  logic [7:0] rx_ctl;
  logic [7:0] rate_ctl;
  logic [7:0] div_low;
  logic [7:0] div_high;
  logic wake_flag;
  logic wr_en;
  logic rd_en;
  logic wr_tx;
  logic wr_rx;
  logic wr_rate;
  logic wr_div;
  logic rd_data;
  logic mapped;
  logic async_mode;
  logic rx_on;
  logic accept;
  logic addr_ok;
  logic full;
  logic [9:0] head;
  logic [1:0] level;
  logic [7:0] next_rx_rd;
  logic [DATA_W-1:0] next_prdata;

  assign mapped = hit(i_paddr, OFF_TX_CTL) || hit(i_paddr, OFF_RX_CTL) ||
                  hit(i_paddr, OFF_RATE_CTL) || hit(i_paddr, OFF_RX_DATA) ||
                  hit(i_paddr, OFF_DIV_LOW) || hit(i_paddr, OFF_DIV_HIGH);
  // zero-wait slave: every access phase completes at once
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign wr_en = i_psel && i_penable && i_pwrite && i_pstrb[0];
  assign rd_en = i_psel && i_penable && !i_pwrite;
  assign wr_tx = wr_en && hit(i_paddr, OFF_TX_CTL);
  assign wr_rx = wr_en && hit(i_paddr, OFF_RX_CTL);
  assign wr_rate = wr_en && hit(i_paddr, OFF_RATE_CTL);
  assign wr_div = wr_en && (hit(i_paddr, OFF_DIV_LOW) ||
                            hit(i_paddr, OFF_DIV_HIGH));
  assign rd_data = rd_en && hit(i_paddr, OFF_RX_DATA);

  assign async_mode = !tx_ctl[TX_SYNC];
  assign o_port_enable = rx_ctl[RX_PORT_EN];
  assign o_sync_mode = tx_ctl[TX_SYNC];
  assign o_clock_master = tx_ctl[TX_SYNC] && tx_ctl[TX_CLK_SRC];
  // sync receive enables steal the shared data pin from the transmitter
  assign o_tx_enable = o_port_enable && tx_ctl[TX_ON] &&
    !(tx_ctl[TX_SYNC] && (rx_ctl[RX_CONT] || rx_ctl[RX_SINGLE]));
  assign o_tx_nine = tx_ctl[TX_NINE];
  assign o_tx_ninth_data = tx_ctl[TX_NINE] && tx_ctl[TX_NINTH_DATA];
  assign o_send_break = async_mode && tx_ctl[TX_BREAK];
  assign o_high_speed = async_mode && tx_ctl[TX_HIGH_SPEED];
  // continuous wins over single in sync; single only as master
  assign rx_on = async_mode ? rx_ctl[RX_CONT] :
    (rx_ctl[RX_CONT] || (o_clock_master && rx_ctl[RX_SINGLE]));
  assign o_rx_enable = o_port_enable && rx_on && !rx_ctl[RX_OVERRUN];
  assign o_rx_nine = rx_ctl[RX_NINE];
  assign o_polarity = rate_ctl[RC_POLARITY];
  assign o_autobaud_run = o_port_enable && async_mode &&
                          rate_ctl[RC_AUTOBAUD];
  assign o_wake_wait = o_port_enable && async_mode && rate_ctl[RC_WAKE];
  assign o_receive_pending = (level != 2'd0) || wake_flag;

  assign addr_ok = !(async_mode && rx_ctl[RX_NINE] &&
                     rx_ctl[RX_ADDR_DET]) || i_rx_char[8];
  assign full = (level == 2'(FIFO_DEPTH));
  // no characters while waking or after an overrun
  assign accept = i_rx_valid && o_rx_enable && !o_wake_wait && addr_ok;

  spcsr_rx_fifo #(
    .WIDTH(10),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_flush(!o_port_enable),
    .i_push(accept && !full),
    .i_data({i_rx_frame_err, i_rx_char}),
    .i_pop(rd_data),
    .o_head(head),
    .o_level(level)
  );

  spcsr_rate_gen #(
    .WIDTH(DIV_W)
  ) u_rate (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_restart(wr_div || !o_port_enable),
    .i_wide(rate_ctl[RC_WIDE]),
    .i_divisor({div_high, div_low}),
    .o_tick(o_rate_tick)
  );

  // transmit control; hardware clear of break loses to a same-cycle write
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      tx_ctl <= TX_CTL_RST;
    end else begin
      if (wr_tx) begin
        tx_ctl[7:2] <= i_pwdata[7:2];
        tx_ctl[TX_NINTH_DATA] <= i_pwdata[TX_NINTH_DATA];
      end else if (i_break_done && o_send_break) begin
        tx_ctl[TX_BREAK] <= 1'b0;
      end
      tx_ctl[TX_SHIFT_EMPTY] <= !o_port_enable || i_tsr_empty;
    end
  end

  // receive control; framing and ninth bits mirror the buffer head
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rx_ctl <= RX_CTL_RST;
    end else begin
      if (wr_rx) begin
        rx_ctl[7:3] <= i_pwdata[7:3];
      end else if (i_single_done && o_clock_master) begin
        rx_ctl[RX_SINGLE] <= 1'b0;
      end
      if (!o_port_enable) begin
        rx_ctl[RX_OVERRUN] <= 1'b0;
      end else if (i_rx_valid && o_rx_enable && addr_ok && full) begin
        rx_ctl[RX_OVERRUN] <= 1'b1;
      end else if (wr_rx && !i_pwdata[RX_CONT]) begin
        rx_ctl[RX_OVERRUN] <= 1'b0;
      end
      // an empty head is unwritten or stale, so both bits read zero
      rx_ctl[RX_FRAME_ERR] <= o_port_enable && (level != 2'd0) &&
                              head[9];
      rx_ctl[RX_NINTH_DATA] <= (level != 2'd0) && head[8];
    end
  end

  // rate control; reserved bits never stored
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rate_ctl <= RATE_CTL_RST;
    end else begin
      if (wr_rate) begin
        rate_ctl[RC_POLARITY] <= i_pwdata[RC_POLARITY];
        rate_ctl[RC_WIDE] <= i_pwdata[RC_WIDE];
        rate_ctl[RC_WAKE] <= i_pwdata[RC_WAKE];
        rate_ctl[RC_AUTOBAUD] <= i_pwdata[RC_AUTOBAUD];
      end else begin
        if (o_wake_wait && i_rx_fall) begin
          rate_ctl[RC_WAKE] <= 1'b0;
        end
        if (o_autobaud_run && i_autobaud_done) begin
          rate_ctl[RC_AUTOBAUD] <= 1'b0;
        end
      end
      // overflow is set by hardware, so it wins over the restart clear
      if (o_autobaud_run && i_autobaud_ovf) begin
        rate_ctl[RC_AB_OVF] <= 1'b1;
      end else if (!o_port_enable ||
                   (wr_rate && i_pwdata[RC_AUTOBAUD])) begin
        rate_ctl[RC_AB_OVF] <= 1'b0;
      end
      rate_ctl[RC_IDLE] <= !(o_port_enable && async_mode &&
                             i_rx_busy);
    end
  end

  // wake event stands in for a character until rx_data is read
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n || !o_port_enable) begin
      wake_flag <= 1'b0;
    end else if (o_wake_wait && i_rx_fall) begin
      wake_flag <= 1'b1;
    end else if (rd_data) begin
      wake_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      div_low <= DIV_RST;
      div_high <= DIV_RST;
    end else if (wr_div) begin
      if (hit(i_paddr, OFF_DIV_LOW)) begin
        div_low <= i_pwdata[7:0];
      end else begin
        div_high <= i_pwdata[7:0];
      end
    end
  end

  always_comb begin
    next_rx_rd = (level != 2'd0) ? head[7:0] : 8'h00;
    next_prdata = '0;
    case (i_paddr)
      ADDR_W'(OFF_TX_CTL): next_prdata[7:0] = tx_ctl;
      ADDR_W'(OFF_RX_CTL): next_prdata[7:0] = rx_ctl;
      ADDR_W'(OFF_RATE_CTL): next_prdata[7:0] = rate_ctl & RC_IMPL_MASK;
      ADDR_W'(OFF_RX_DATA): next_prdata[7:0] = next_rx_rd;
      ADDR_W'(OFF_DIV_LOW): next_prdata[7:0] = div_low;
      ADDR_W'(OFF_DIV_HIGH): next_prdata[7:0] = div_high;
      default: next_prdata = '0;
    endcase
  end

  // registered in setup so data is stable for the access edge
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_prdata <= '0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= next_prdata;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_wake_armed;
    o_wake_wait && i_rx_fall && !wr_rate;
  endsequence
  sequence s_woken;
    !rate_ctl[RC_WAKE] && wake_flag ##0 o_receive_pending;
  endsequence

  AST_WAKE_FLAG: assert property (s_wake_armed |=> s_woken)
    else $error("wake edge did not raise pending flag");
  AST_BREAK_CLEAR: assert property (o_send_break && i_break_done &&
    !wr_tx |=> !tx_ctl[TX_BREAK])
    else $error("break request not cleared after break");
  AST_OVERRUN_CLEAR: assert property (wr_rx &&
    !i_pwdata[RX_CONT] && !(i_rx_valid && o_rx_enable)
    |=> !rx_ctl[RX_OVERRUN])
    else $error("overrun not cleared by receive disable");
  AST_TRANSMITTER_ON_PRIO: assert property (tx_ctl[TX_SYNC] &&
    (rx_ctl[RX_CONT] || rx_ctl[RX_SINGLE]) |-> !o_tx_enable)
    else $error("transmitter enabled over sync receive");
  AST_ADDR_FILTER: assert property (i_rx_valid && !i_rx_char[8] &&
    async_mode && rx_ctl[RX_NINE] && rx_ctl[RX_ADDR_DET] && !rd_data
    |=> level == $past(level))
    else $error("data character loaded under address detect");
  AST_PORT_OFF: assert property (!o_port_enable |=> level == 2'd0 &&
    !rx_ctl[RX_OVERRUN] ##1 !rx_ctl[RX_FRAME_ERR] || o_port_enable)
    else $error("disabled port not held in reset");
  AST_HS_SYNC: assert property (tx_ctl[TX_SYNC] |-> !o_high_speed)
    else $error("high-speed select active in sync mode");
  AST_IDLE: assert property (o_port_enable && async_mode && i_rx_busy
    |=> !rate_ctl[RC_IDLE])
    else $error("idle flag high during reception");
  AST_SHIFT_EMPTY: assert property (o_port_enable && !i_tsr_empty
    |=> !tx_ctl[TX_SHIFT_EMPTY])
    else $error("shift-empty flag ignores full shift register");
  AST_SINGLE_CLEAR: assert property (o_clock_master &&
    i_single_done && !wr_rx |=> !rx_ctl[RX_SINGLE])
    else $error("single receive not cleared");

  // buffer, error flag and auto-baud checks
  AST_OVERRUN_SET: assert property (i_rx_valid && o_rx_enable &&
    addr_ok && full |=> rx_ctl[RX_OVERRUN])
    else $error("overrun not flagged on full buffer");
  AST_FULL_HOLD: assert property (i_rx_valid && full && !rd_data &&
    o_port_enable |=> full)
    else $error("character pushed into full buffer");
  AST_FRAMING_ERROR_FLAG_HEAD: assert property (o_port_enable &&
    level != 2'd0 && head[9] |=> rx_ctl[RX_FRAME_ERR])
    else $error("framing flag does not follow buffer head");
  AST_AB_OVF: assert property (o_autobaud_run && i_autobaud_ovf
    |=> rate_ctl[RC_AB_OVF])
    else $error("auto-baud overflow not flagged");
  AST_AB_CLEAR: assert property (o_autobaud_run &&
    i_autobaud_done && !wr_rate |=> !rate_ctl[RC_AUTOBAUD])
    else $error("auto-baud enable not cleared on completion");
endmodule // spcsr_regs

// File: sim/spcsr_engine_model.sv
`timescale 1ns/10ps
module spcsr_engine_model (
  input wire logic i_clk_sys,
  input wire logic i_send_break,
  input wire logic i_autobaud_run,
  output logic o_tsr_empty,
  output logic o_break_done,
  output logic o_single_done,
  output logic o_rx_busy,
  output logic o_rx_valid,
  output logic [8:0] o_rx_char,
  output logic o_rx_frame_err,
  output logic o_rx_fall,
  output logic o_autobaud_done,
  output logic o_autobaud_ovf
);
  logic [2:0] brk_cnt;
  logic [2:0] ab_cnt;
  initial begin
    {o_break_done, o_single_done, o_rx_busy, o_rx_valid} = 4'h0;
    {o_rx_frame_err, o_rx_fall, o_autobaud_done, o_autobaud_ovf} = 4'h0;
    o_tsr_empty = 1'b1;
    o_rx_char = 9'h000;
    brk_cnt = 3'h0;
    ab_cnt = 3'h0;
  end
  // the break takes a few cycles on the line before it reports done
  always @(posedge i_clk_sys) begin
    o_break_done <= 1'b0;
    brk_cnt <= 3'h0;
    if (i_send_break && !o_break_done) begin
      brk_cnt <= brk_cnt + 3'h1;
      if (brk_cnt == 3'h3) o_break_done <= 1'b1;
    end
  end
  always @(posedge i_clk_sys) begin
    o_autobaud_done <= 1'b0;
    ab_cnt <= 3'h0;
    if (i_autobaud_run && !o_autobaud_done) begin
      ab_cnt <= ab_cnt + 3'h1;
      if (ab_cnt == 3'h3) o_autobaud_done <= 1'b1;
    end
  end
  task send(input logic [8:0] c, input logic fe);
    @(posedge i_clk_sys);
    o_rx_busy <= 1'b1;
    @(posedge i_clk_sys);
    @(posedge i_clk_sys);
    o_rx_busy <= 1'b0;
    o_rx_valid <= 1'b1;
    o_rx_char <= c;
    o_rx_frame_err <= fe;
    @(posedge i_clk_sys);
    // character gone: show garbage, not a stale copy
    o_rx_valid <= 1'b0;
    o_rx_char <= ~c;
    o_rx_frame_err <= ~fe;
  endtask
  task pulse(input int which);
    @(posedge i_clk_sys);
    if (which == 0) o_single_done <= 1'b1;
    if (which == 1) o_rx_fall <= 1'b1;
    if (which == 2) o_autobaud_ovf <= 1'b1;
    @(posedge i_clk_sys);
    {o_single_done, o_rx_fall, o_autobaud_ovf} <= 3'h0;
  endtask
  task set_busy(input logic v);
    @(posedge i_clk_sys);
    o_rx_busy <= v;
  endtask
  task set_empty(input logic v);
    @(posedge i_clk_sys);
    o_tsr_empty <= v;
  endtask
endmodule // spcsr_engine_model

// File: sim/spcsr_regs_tb.sv
`timescale 1ns/10ps
module spcsr_regs_tb;
  import spcsr_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [3:0] strb_sel = 4'hf;
  logic [31:0] rq;
  logic perr;
  logic pready, pslverr, tsr_e, brk_d, sgl_d, busy, rxv, fe, fall;
  logic ab_d, ab_o, port_en, sync, master, tx_en, tx9, tx_ninth_data, sbrk, hs;
  logic rx_en, rx9, pol, ab_run, wake, tick, pend;
  logic [31:0] prdata;
  logic [8:0] rx_char;
  int failures = 0;
  int total_checks = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  spcsr_regs uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata), .i_tsr_empty(tsr_e),
    .i_break_done(brk_d), .i_single_done(sgl_d), .i_rx_busy(busy),
    .i_rx_valid(rxv), .i_rx_char(rx_char), .i_rx_frame_err(fe),
    .i_rx_fall(fall), .i_autobaud_done(ab_d), .i_autobaud_ovf(ab_o),
    .o_port_enable(port_en), .o_sync_mode(sync), .o_clock_master(master),
    .o_tx_enable(tx_en), .o_tx_nine(tx9), .o_tx_ninth_data(tx_ninth_data),
    .o_send_break(sbrk), .o_high_speed(hs), .o_rx_enable(rx_en),
    .o_rx_nine(rx9), .o_polarity(pol), .o_autobaud_run(ab_run),
    .o_wake_wait(wake), .o_rate_tick(tick), .o_receive_pending(pend));
  spcsr_engine_model u_model (.i_clk_sys(i_clk_sys), .i_send_break(sbrk),
    .i_autobaud_run(ab_run), .o_tsr_empty(tsr_e), .o_break_done(brk_d),
    .o_single_done(sgl_d), .o_rx_busy(busy), .o_rx_valid(rxv),
    .o_rx_char(rx_char), .o_rx_frame_err(fe), .o_rx_fall(fall),
    .o_autobaud_done(ab_d), .o_autobaud_ovf(ab_o));
  task test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb_sel;
    @(posedge i_clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      test_done;
    end
    rq = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rq, {24'h0, exp});
  endtask
  task cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task wait_tick(output int n);
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (tick !== 1'b1 && n < 600);
    if (tick !== 1'b1) begin
      failures++;
      test_done;
    end
  endtask
  task gap(input int exp);
    int n;
    wait_tick(n);
    wait_tick(n);
    chk(32'(n), 32'(exp));
  endtask
  task t_reset;
    rd(OFF_TX_CTL, 8'h02);
    rd(OFF_RX_CTL, 8'h00);
    rd(OFF_RATE_CTL, 8'h40);
    rd(OFF_DIV_LOW, 8'h00);
    rd(8'h18, 8'h00);
    chk1(perr, 1'b1);
  endtask
  task t_tx;
    wr(OFF_RX_CTL, 8'h80);
    chk1(port_en, 1'b1);
    wr(OFF_TX_CTL, 8'hf4);
    chk1(master, 1'b1);
    chk1(tx9, 1'b1);
    chk1(sync, 1'b1);
    chk1(tx_en, 1'b1);
    chk1(hs, 1'b0);
    wr(OFF_TX_CTL, 8'h74);
    chk1(master, 1'b0);
    wr(OFF_RX_CTL, 8'h90);
    chk1(tx_en, 1'b0);
    wr(OFF_TX_CTL, 8'h65);
    chk1(hs, 1'b1);
    chk1(tx_ninth_data, 1'b1);
    chk1(tx_en, 1'b1);
    rd(OFF_TX_CTL, 8'h67);
    u_model.set_empty(1'b0);
    wr(OFF_TX_CTL, 8'h63);
    rd(OFF_TX_CTL, 8'h61);
    u_model.set_empty(1'b1);
    wr(OFF_TX_CTL, 8'h68);
    chk1(sbrk, 1'b1);
    cyc(10);
    rd(OFF_TX_CTL, 8'h62);
  endtask
  task t_rx;
    wr(OFF_RX_CTL, 8'hd0);
    chk1(rx_en, 1'b1);
    chk1(rx9, 1'b1);
    u_model.send(9'h1a5, 1'b1);
    u_model.send(9'h05a, 1'b0);
    cyc(2);
    chk1(pend, 1'b1);
    // ninth bit stored raw, parity left to software
    rd(OFF_RX_CTL, 8'hd5);
    rd(OFF_RX_DATA, 8'ha5);
    rd(OFF_RX_CTL, 8'hd0);
    rd(OFF_RX_DATA, 8'h5a);
    cyc(1);
    chk1(pend, 1'b0);
    u_model.send(9'h011, 1'b0);
    u_model.send(9'h022, 1'b0);
    u_model.send(9'h033, 1'b0);
    cyc(2);
    rd(OFF_RX_CTL, 8'hd2);
    wr(OFF_RX_CTL, 8'hc0);
    rd(OFF_RX_CTL, 8'hc0);
    rd(OFF_RX_DATA, 8'h11);
    rd(OFF_RX_DATA, 8'h22);
    rd(OFF_RX_DATA, 8'h00);
    wr(OFF_RX_CTL, 8'hd8);
    u_model.send(9'h044, 1'b0);
    u_model.send(9'h155, 1'b0);
    cyc(2);
    rd(OFF_RX_DATA, 8'h55);
    cyc(1);
    chk1(pend, 1'b0);
    u_model.send(9'h166, 1'b0);
    cyc(2);
    wr(OFF_RX_CTL, 8'h40);
    cyc(1);
    chk1(pend, 1'b0);
    chk1(port_en, 1'b0);
    wr(OFF_TX_CTL, 8'h90);
    wr(OFF_RX_CTL, 8'ha0);
    chk1(rx_en, 1'b1);
    u_model.pulse(0);
    rd(OFF_RX_CTL, 8'h80);
  endtask
  task t_rate;
    int n;
    wr(OFF_TX_CTL, 8'h20);
    wr(OFF_RX_CTL, 8'h90);
    wr(OFF_RATE_CTL, 8'hff);
    chk1(ab_run, 1'b1);
    chk1(wake, 1'b1);
    chk1(pol, 1'b1);
    // overflow only counts while detection is still running
    u_model.pulse(2);
    cyc(8);
    u_model.pulse(1);
    rd(OFF_RATE_CTL, 8'hd8);
    chk1(pend, 1'b1);
    rd(OFF_RX_DATA, 8'h00);
    cyc(1);
    chk1(pend, 1'b0);
    u_model.set_busy(1'b1);
    rd(OFF_RATE_CTL, 8'h98);
    u_model.set_busy(1'b0);
    wr(OFF_RATE_CTL, 8'h10);
    wr(OFF_DIV_LOW, 8'h03);
    gap(4);
    wr(OFF_DIV_HIGH, 8'h01);
    gap(4);
    wr(OFF_RATE_CTL, 8'h18);
    gap(260);
    wr(OFF_DIV_HIGH, 8'h00);
    wait_tick(n);
    // timer cleared at the write edge; tick seen five edges later
    chk(32'(n), 32'd5);
    strb_sel = 4'h0;
    wr(OFF_DIV_LOW, 8'h55);
    strb_sel = 4'hf;
    rd(OFF_DIV_LOW, 8'h03);
  endtask
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_rate;
    test_done;
  end
endmodule // spcsr_regs_tb
